// file: src/srr_status_regs.sv
// Status reporting register bank driven by decoded command messages
//
// Overview of operation
// - Standard event mask is an 8-bit set and query register.
// - Service request mask is an 8-bit set and query register.
// - Status byte is query only; nothing writes it.
// - Standard event latch is query only, 8 bits.
// - Operation condition is a read-only 16-bit live status.
// - Operation event latch is a read-only 16-bit latched value.
// - Operation event mask is a 16-bit set and query register.
// - Fault condition is a read-only 16-bit live fault status.
// - Fault event latch is a read-only 16-bit latched value.
// - Fault event mask is a 16-bit set and query register.
// - Clear empties event latches and status byte except message available.
// - Power-up clears event latches but sets the power-on flag.
// - Power-up empties queues, clears masks, status, opens path.
// - Reset command restores only device settings; status untouched.
// - Operation-complete command sets its flag when pending work ends.
// - Operation-complete query answers ASCII one after pending work ends.
// - Wait command holds off later messages until pending work ends.
// - Remote state entered on communication, lamp lit, never left.
// - Status preset does the same as the reset command.
// - Self-test query runs a test and answers pass or fail.
// - Enabled operation events set bit 7, fault events bit 3.
// - Querying a group event latch clears it.
// - Standard event bit counts only when its mask bit is one.
`timescale 1ns/10ps
module srr_status_regs #(
	parameter int TEST_LEN = srr_pkg::TEST_CYCLES
) (
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	input  wire srr_pkg::srr_req_s req,
	input  wire logic              req_valid,
	input  wire logic              pending_busy,
	input  wire logic              msg_available,
	input  wire logic [5:1]        std_event_in,
	input  wire logic [15:0]       oper_cond_in,
	input  wire logic [15:0]       fault_cond_in,
	input  wire logic              test_fail,
	output logic                   req_ready,
	output srr_pkg::srr_rsp_s      rsp,
	output logic                   settings_default,
	output logic                   queue_flush,
	output logic                   path_open,
	output logic                   remote_lamp
);

	typedef enum {
		ST_IDLE,
		ST_DONE_WAIT,
		ST_DONEQ_WAIT,
		ST_WAI_WAIT,
		ST_TEST
	} srr_state_e;

	srr_state_e  state;
	logic [7:0]  service_request_mask;
	logic [7:0]  standard_event_latch;
	logic [7:0]  standard_event_mask;
	logic [7:0]  std_in_prev;
	logic [15:0] operation_condition;
	logic [15:0] operation_event_latch;
	logic [15:0] operation_event_mask;
	logic [15:0] fault_condition;
	logic [15:0] fault_event_latch;
	logic [15:0] fault_event_mask;
	logic        operation_summary_bit;
	logic        fault_summary_bit;
	logic        std_summary;
	logic        msg_avail_q;
	logic [7:0]  status_summary_byte;
	logic [15:0] test_cnt;
	logic        take;
	logic        is_cls;
	logic        op_done;
	logic [7:0]  std_src;

	srr_pkg::srr_cmd_e cmd;

	assign cmd    = req.cmd;
	assign take   = req_valid && req_ready;
	assign is_cls = take && (cmd == srr_pkg::SRR_CLS);
	assign std_src = {2'b00, std_event_in, 1'b0};

	// Operation group
	srr_event_group #(
		.WIDTH(16)
	) u_oper (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.cond_in   (oper_cond_in),
		.mask_wr   (take && cmd == srr_pkg::SRR_OENA_SET),
		.mask_data (req.data),
		.evt_clear (is_cls || (take && cmd == srr_pkg::SRR_OEVT_Q)),
		.cond      (operation_condition),
		.evt       (operation_event_latch),
		.mask      (operation_event_mask),
		.summary   (operation_summary_bit)
	);

	// Fault group
	srr_event_group #(
		.WIDTH(16)
	) u_fault (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.cond_in   (fault_cond_in),
		.mask_wr   (take && cmd == srr_pkg::SRR_QENA_SET),
		.mask_data (req.data),
		.evt_clear (is_cls || (take && cmd == srr_pkg::SRR_QEVT_Q)),
		.cond      (fault_condition),
		.evt       (fault_event_latch),
		.mask      (fault_event_mask),
		.summary   (fault_summary_bit)
	);

	// Standard event sources from the parser, latched on rising edge
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			std_in_prev <= srr_pkg::BYTE_RST;
		end else begin
			std_in_prev <= std_src;
		end
	end

	// Standard event latch; power-on flag is the reset value
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			standard_event_latch <= srr_pkg::STD_POWER_ON;
		end else begin
			for (int b = 0; b < 8; b++) begin
				if (b == srr_pkg::OP_DONE_BIT && op_done) begin
					standard_event_latch[b] <= 1'b1;
				end else if (std_src[b] && !std_in_prev[b]) begin
					standard_event_latch[b] <= 1'b1;
				end else if (is_cls ||
				             (take && cmd == srr_pkg::SRR_ESR_Q)) begin
					standard_event_latch[b] <= 1'b0;
				end
			end
		end
	end

	// Host masks; reset and preset commands leave them alone
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			standard_event_mask  <= srr_pkg::BYTE_RST;
			service_request_mask <= srr_pkg::BYTE_RST;
		end else if (take) begin
			if (cmd == srr_pkg::SRR_ESE_SET) begin
				standard_event_mask <= req.data[7:0];
			end
			if (cmd == srr_pkg::SRR_SRE_SET) begin
				service_request_mask <= req.data[7:0];
			end
		end
	end

	// Standard summary uses only enabled bits
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			std_summary <= 1'b0;
			msg_avail_q <= 1'b0;
		end else begin
			std_summary <= |(standard_event_latch &
			                 standard_event_mask);
			msg_avail_q <= msg_available;
		end
	end

	// Status byte is built from summaries and message available, never written
	always_comb begin
		status_summary_byte = srr_pkg::BYTE_RST;
		status_summary_byte[srr_pkg::OPER_SUM_BIT]  = operation_summary_bit;
		status_summary_byte[srr_pkg::FAULT_SUM_BIT] = fault_summary_bit;
		status_summary_byte[srr_pkg::MSG_AVAIL_BIT] = msg_avail_q;
		status_summary_byte[srr_pkg::STD_SUM_BIT]   = std_summary;
		status_summary_byte[srr_pkg::RQS_BIT] =
			|(status_summary_byte & service_request_mask);
	end

	// Sequencer for operation complete, wait and self-test
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
		end else begin
			case (state)
			ST_IDLE: begin
				if (take) begin
					case (cmd)
					srr_pkg::SRR_DONE:   state <= ST_DONE_WAIT;
					srr_pkg::SRR_DONE_Q: state <= ST_DONEQ_WAIT;
					srr_pkg::SRR_WAI:   state <= ST_WAI_WAIT;
					srr_pkg::SRR_TST_Q: state <= ST_TEST;
					default:            state <= ST_IDLE;
					endcase
				end
			end
			ST_DONE_WAIT, ST_DONEQ_WAIT, ST_WAI_WAIT: begin
				if (!pending_busy) begin
					state <= ST_IDLE;
				end
			end
			ST_TEST: begin
				if (test_cnt == 16'(TEST_LEN - 1)) begin
					state <= ST_IDLE;
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// Operation-complete flag raised as pending work drains
	assign op_done = (state == ST_DONE_WAIT) && !pending_busy;

	// Self-test cycle counter
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			test_cnt <= '0;
		end else if (state == ST_TEST) begin
			test_cnt <= test_cnt + 16'h0001;
		end else begin
			test_cnt <= '0;
		end
	end

	// Accept new messages only when idle; wait holds the parser off
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_ready <= 1'b0;
		end else begin
			req_ready <= (state == ST_IDLE) && !take;
		end
	end

	// Query answers, one cycle pulse
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp <= '0;
		end else begin
			rsp.valid <= 1'b0;
			rsp.data  <= rsp.data;
			if (take) begin
				rsp.valid <= 1'b1;
				case (cmd)
				srr_pkg::SRR_SUM_Q:   rsp.data <= {8'h00, status_summary_byte};
				srr_pkg::SRR_SRE_Q:   rsp.data <= {8'h00, service_request_mask};
				srr_pkg::SRR_ESR_Q:   rsp.data <= {8'h00, standard_event_latch};
				srr_pkg::SRR_ESE_Q:   rsp.data <= {8'h00, standard_event_mask};
				srr_pkg::SRR_OCOND_Q: rsp.data <= operation_condition;
				srr_pkg::SRR_OEVT_Q:  rsp.data <= operation_event_latch;
				srr_pkg::SRR_OENA_Q:  rsp.data <= operation_event_mask;
				srr_pkg::SRR_QCOND_Q: rsp.data <= fault_condition;
				srr_pkg::SRR_QEVT_Q:  rsp.data <= fault_event_latch;
				srr_pkg::SRR_QENA_Q:  rsp.data <= fault_event_mask;
				default:              rsp.valid <= 1'b0;
				endcase
			end else if (state == ST_DONEQ_WAIT && !pending_busy) begin
				rsp.valid <= 1'b1;
				rsp.data  <= {8'h00, srr_pkg::ASCII_ONE};
			end else if (state == ST_TEST &&
			             test_cnt == 16'(TEST_LEN - 1)) begin
				rsp.valid <= 1'b1;
				rsp.data  <= {8'h00, test_fail ? srr_pkg::ASCII_ZERO
				                               : srr_pkg::ASCII_ONE};
			end
		end
	end

	// Reset and preset only pulse the device settings default strobe
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			settings_default <= 1'b0;
		end else begin
			settings_default <= take && (cmd == srr_pkg::SRR_RST ||
			                             cmd == srr_pkg::SRR_PRESET);
		end
	end

	// Power-up flush of queues and opening of the path, one cycle after
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			queue_flush <= 1'b1;
			path_open   <= 1'b1;
		end else begin
			queue_flush <= 1'b0;
			path_open   <= 1'b0;
		end
	end

	// Remote state is sticky until power goes
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			remote_lamp <= 1'b0;
		end else if (take) begin
			remote_lamp <= 1'b1;
		end
	end

	// Standard event mask survives the reset command
	mask_keep_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(take && cmd == srr_pkg::SRR_RST) |=> $stable(standard_event_mask))
		else $error("mask changed on reset command");

	ese_write_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(take && cmd == srr_pkg::SRR_ESE_SET) |=>
		standard_event_mask == $past(req.data[7:0]))
		else $error("event mask write lost");

	sre_write_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(take && cmd == srr_pkg::SRR_SRE_SET) |=>
		service_request_mask == $past(req.data[7:0]))
		else $error("request mask write lost");

	// Only a bit whose condition was set at the query edge may survive it
	oper_clear_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(take && cmd == srr_pkg::SRR_OEVT_Q) |=>
		(operation_event_latch & ~$past(operation_condition)) == 16'h0000)
		else $error("operation event not cleared by query");

	cls_keep_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		is_cls |=> $stable(operation_event_mask) && $stable(fault_event_mask))
		else $error("clear touched enable masks");

	done_flag_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		op_done |=> standard_event_latch[srr_pkg::OP_DONE_BIT])
		else $error("operation complete flag not set");

	wai_hold_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(state == ST_WAI_WAIT) |-> !req_ready)
		else $error("messages taken while waiting");

	remote_stay_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		remote_lamp |=> remote_lamp)
		else $error("remote state left");

	done_ans_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(state == ST_DONEQ_WAIT && !pending_busy) |=>
		rsp.valid && rsp.data[7:0] == srr_pkg::ASCII_ONE)
		else $error("operation complete query answer wrong");

	sum_oper_a: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(|(operation_event_latch & operation_event_mask)) |=>
		status_summary_byte[srr_pkg::OPER_SUM_BIT])
		else $error("operation summary bit missing");

endmodule

// file: src/srr_pkg.sv
// Shared constants, command codes and carriers for the status reporting block
package srr_pkg;

	// Status byte bit positions
	localparam int FAULT_SUM_BIT = 3;   // fault_summary_bit
	localparam int MSG_AVAIL_BIT = 4;   // message_available_flag
	localparam int STD_SUM_BIT   = 5;   // standard event summary
	localparam int RQS_BIT       = 6;   // service request summary
	localparam int OPER_SUM_BIT  = 7;   // operation_summary_bit

	// Standard event bit positions
	localparam int OP_DONE_BIT  = 0;    // operation_complete_flag
	localparam int POWER_ON_BIT = 7;    // power_on_flag

	// Values after reset
	localparam logic [7:0]  BYTE_RST  = 8'h00;
	localparam logic [15:0] WORD_RST  = 16'h0000;
	localparam logic [7:0]  STD_POWER_ON = 8'h80;

	// Self-test length in cycles
	localparam int TEST_CYCLES = 16;

	// Result characters
	localparam logic [7:0] ASCII_ONE  = 8'h31;
	localparam logic [7:0] ASCII_ZERO = 8'h30;

	// Commands decoded from the message parser
	typedef enum logic [4:0] {
		SRR_NOP,
		SRR_SUM_Q,
		SRR_SRE_SET,
		SRR_SRE_Q,
		SRR_ESR_Q,
		SRR_ESE_SET,
		SRR_ESE_Q,
		SRR_OCOND_Q,
		SRR_OEVT_Q,
		SRR_OENA_SET,
		SRR_OENA_Q,
		SRR_QCOND_Q,
		SRR_QEVT_Q,
		SRR_QENA_SET,
		SRR_QENA_Q,
		SRR_CLS,
		SRR_RST,
		SRR_PRESET,
		SRR_DONE,
		SRR_DONE_Q,
		SRR_WAI,
		SRR_TST_Q
	} srr_cmd_e;

	// Command request carrier
	typedef struct packed {
		srr_cmd_e    cmd;
		logic [15:0] data;
	} srr_req_s;

	// Answer carrier
	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} srr_rsp_s;

endpackage

// file: src/srr_event_group.sv
// One latched event group: condition, event latch, mask and summary
`timescale 1ns/10ps
module srr_event_group #(
	parameter int WIDTH = 16
) (
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] cond_in,
	input  wire logic             mask_wr,
	input  wire logic [WIDTH-1:0] mask_data,
	input  wire logic             evt_clear,
	output logic      [WIDTH-1:0] cond,
	output logic      [WIDTH-1:0] evt,
	output logic      [WIDTH-1:0] mask,
	output logic                  summary
);

	logic [WIDTH-1:0] cond_prev;

	// Condition sampled so rising edges can be found
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cond      <= '0;
			cond_prev <= '0;
		end else begin
			cond      <= cond_in;
			cond_prev <= cond;
		end
	end

	// Per bit latch; a new edge beats a clear in the same cycle
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					evt[i] <= 1'b0;
				end else if (cond[i] && !cond_prev[i]) begin
					evt[i] <= 1'b1;
				end else if (evt_clear) begin
					evt[i] <= 1'b0;
				end
			end
		end
	endgenerate

	// Mask only changes on its set command
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mask <= '0;
		end else if (mask_wr) begin
			mask <= mask_data;
		end
	end

	// Summary registered to keep top outputs flopped
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			summary <= 1'b0;
		end else begin
			summary <= |(evt & mask);
		end
	end

endmodule

// file: tb/srr_host_model.sv
// Remote controller model that offers decoded command messages
`timescale 1ns/10ps
module srr_host_model (
	input  wire logic              core_clk,
	input  wire logic              req_ready,
	input  wire srr_pkg::srr_rsp_s rsp,
	output srr_pkg::srr_req_s      req,
	output logic                   req_valid
);
	localparam int LIM = 200;

	// Request lines idle at time zero
	initial begin
		req_valid = 1'b0;
		req       = '0;
	end

	// Offer one command, hold it until taken, then collect any answer
	task automatic xfer(
		input  srr_pkg::srr_cmd_e c,
		input  logic [15:0]       d,
		input  bit                q,
		output logic [15:0]       r,
		output int                wt,
		output bit                to
	);
		int na;
		na = 0;
		wt = 0;
		r  = 16'h0000;
		@(negedge core_clk);
		req.cmd   = c;
		req.data  = d; // 8-bit values ride in the low byte
		req_valid = 1'b1;
		// Ready only moves on rising edges, so a falling-edge look is safe
		while (req_ready !== 1'b1 && wt < LIM) begin
			@(negedge core_clk);
			wt++;
		end
		@(posedge core_clk);
		@(negedge core_clk);
		// Released lines show a fresh pattern so stale data cannot pass
		req_valid = 1'b0;
		req.cmd   = srr_pkg::SRR_NOP;
		req.data  = ~d;
		if (q) begin
			while (rsp.valid !== 1'b1 && na < LIM) begin
				@(negedge core_clk);
				na++;
			end
			r = rsp.data;
		end
		to = (wt >= LIM) || (na >= LIM);
		wt = wt + na;
	endtask
endmodule

// file: tb/status_reporting_registers_tb.sv
// Self-checking bench for the status reporting register bank
`timescale 1ns/10ps
module status_reporting_registers_tb;
	logic              core_clk;
	logic              rst_n;
	srr_pkg::srr_req_s req;
	logic              req_valid;
	logic              pending_busy;
	logic              msg_available;
	logic [5:1]        std_event_in;
	logic [15:0]       oper_cond_in;
	logic [15:0]       fault_cond_in;
	logic              test_fail;
	logic              req_ready;
	srr_pkg::srr_rsp_s rsp;
	logic              settings_default;
	logic              queue_flush;
	logic              path_open;
	logic              remote_lamp;
	int                n_fail;
	int                checks_done;
	int                n_dflt;
	int                k;
	int                wt;
	srr_pkg::srr_cmd_e ini [2];

	// Short self-test keeps the run brief
	srr_status_regs #(.TEST_LEN(4)) u_dut (
		.core_clk         (core_clk),
		.rst_n            (rst_n),
		.req              (req),
		.req_valid        (req_valid),
		.pending_busy     (pending_busy),
		.msg_available    (msg_available),
		.std_event_in     (std_event_in),
		.oper_cond_in     (oper_cond_in),
		.fault_cond_in    (fault_cond_in),
		.test_fail        (test_fail),
		.req_ready        (req_ready),
		.rsp              (rsp),
		.settings_default (settings_default),
		.queue_flush      (queue_flush),
		.path_open        (path_open),
		.remote_lamp      (remote_lamp)
	);

	srr_host_model u_host (
		.core_clk  (core_clk),
		.req_ready (req_ready),
		.rsp       (rsp),
		.req       (req),
		.req_valid (req_valid)
	);

	// Free-running device clock, 100 ns period
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// Count default-settings pulses from reset and preset commands
	always @(posedge core_clk) begin
		if (settings_default === 1'b1) begin
			n_dflt++;
		end
	end

	task automatic summarize();
		if (n_fail == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// One command through the host; a lost handshake ends the run
	task automatic cmd(input srr_pkg::srr_cmd_e c, input logic [15:0] d,
		input bit q, input logic [15:0] e);
		logic [15:0] r;
		bit          to;
		u_host.xfer(c, d, q, r, wt, to);
		if (to) begin
			n_fail++;
			$display("unexpected at %0t: no handshake", $time);
			summarize();
		end
		if (q) begin
			chk(r, e);
		end
	endtask

	task automatic qry(input srr_pkg::srr_cmd_e c, input logic [15:0] e);
		cmd(c, 16'h0000, 1'b1, e);
	endtask

	task automatic set(input srr_pkg::srr_cmd_e c, input logic [15:0] d);
		cmd(c, d, 1'b0, 16'h0000);
	endtask

	// Query held off by pending work; w is the exact wait from offer to
	// answer: busy drops after eight cycles, then the hand-back follows
	task automatic held(input srr_pkg::srr_cmd_e first,
		input srr_pkg::srr_cmd_e c, input logic [15:0] e, input int w);
		pending_busy = 1'b1;
		if (first != srr_pkg::SRR_NOP) begin
			set(first, 16'h0000);
		end
		fork
			qry(c, e);
			begin
				repeat (8) @(negedge core_clk);
				pending_busy = 1'b0;
			end
		join
		chk(16'(wt), 16'(w));
	endtask

	// Main sequence
	initial begin
		rst_n         = 1'b0;
		pending_busy  = 1'b0;
		msg_available = 1'b0;
		std_event_in  = 5'h00;
		oper_cond_in  = 16'h0000;
		fault_cond_in = 16'h0000;
		test_fail     = 1'b0;
		n_fail        = 0;
		checks_done   = 0;
		n_dflt        = 0;
		ini           = '{srr_pkg::SRR_RST, srr_pkg::SRR_PRESET};
		repeat (20) @(negedge core_clk);
		chk({13'h0, remote_lamp, path_open, queue_flush}, 16'h0003);
		rst_n = 1'b1;
		repeat (2) @(negedge core_clk);
		chk({14'h0, path_open, queue_flush}, 16'h0000);
		qry(srr_pkg::SRR_SUM_Q, 16'h0000);
		chk({15'h0, remote_lamp}, 16'h0001);
		qry(srr_pkg::SRR_SRE_Q, 16'h0000);
		qry(srr_pkg::SRR_OENA_Q, 16'h0000);
		qry(srr_pkg::SRR_QENA_Q, 16'h0000);
		set(srr_pkg::SRR_ESE_SET, 16'h00ff);
		qry(srr_pkg::SRR_ESE_Q, 16'h00ff);
		qry(srr_pkg::SRR_SUM_Q, 16'h0020);
		set(srr_pkg::SRR_SRE_SET, 16'h00a5);
		qry(srr_pkg::SRR_SRE_Q, 16'h00a5);
		qry(srr_pkg::SRR_SUM_Q, 16'h0060);
		set(srr_pkg::SRR_OENA_SET, 16'hffff);
		qry(srr_pkg::SRR_OENA_Q, 16'hffff);
		set(srr_pkg::SRR_QENA_SET, 16'h8100);
		qry(srr_pkg::SRR_QENA_Q, 16'h8100);
		// Conditions rise, latch, summarise and clear on read
		oper_cond_in  = 16'h0c30;
		fault_cond_in = 16'h0180;
		repeat (3) @(negedge core_clk);
		qry(srr_pkg::SRR_SUM_Q, 16'h00e8);
		qry(srr_pkg::SRR_OCOND_Q, 16'h0c30);
		qry(srr_pkg::SRR_QCOND_Q, 16'h0180);
		qry(srr_pkg::SRR_OEVT_Q, 16'h0c30);
		qry(srr_pkg::SRR_OEVT_Q, 16'h0000);
		qry(srr_pkg::SRR_QEVT_Q, 16'h0180);
		qry(srr_pkg::SRR_QEVT_Q, 16'h0000);
		qry(srr_pkg::SRR_SUM_Q, 16'h0060);
		qry(srr_pkg::SRR_ESR_Q, 16'h0080);
		// Clear command keeps message-available and the masks
		oper_cond_in  = 16'h0c33;
		msg_available = 1'b1;
		repeat (3) @(negedge core_clk);
		set(srr_pkg::SRR_CLS, 16'h0000);
		qry(srr_pkg::SRR_SUM_Q, 16'h0010);
		qry(srr_pkg::SRR_OEVT_Q, 16'h0000);
		qry(srr_pkg::SRR_ESR_Q, 16'h0000);
		qry(srr_pkg::SRR_ESE_Q, 16'h00ff);
		std_event_in = 5'h02;
		@(negedge core_clk);
		std_event_in = 5'h00;
		qry(srr_pkg::SRR_ESR_Q, 16'h0004);
		// Reset and preset touch only device settings
		for (int i = 0; i < 2; i++) begin
			k = n_dflt;
			set(ini[i], 16'h0000);
			repeat (3) @(negedge core_clk);
			chk(16'(n_dflt - k), 16'h0001);
			qry(srr_pkg::SRR_OENA_Q, 16'hffff);
			chk({13'h0, remote_lamp, path_open, queue_flush}, 16'h0004);
		end
		set(srr_pkg::SRR_CLS, 16'h0000);
		held(srr_pkg::SRR_DONE, srr_pkg::SRR_ESR_Q, 16'h0001, 9);
		held(srr_pkg::SRR_NOP, srr_pkg::SRR_DONE_Q, 16'h0031, 7);
		held(srr_pkg::SRR_WAI, srr_pkg::SRR_SRE_Q, 16'h00a5, 9);
		// Self-test passes, then fails
		for (int i = 0; i < 2; i++) begin
			test_fail = i[0];
			qry(srr_pkg::SRR_TST_Q, 16'h0031 - 16'(i));
		end
		summarize();
	end
endmodule
